/* File: rtl/bnq_defines.svh */
// Constants of the band norm quantiser and differential norm coder.
// Definitions only; included by bare name from the coder only.
// Functional notes
// - Band norm is the rms of the band's coefficients.
// - Band length is last coefficient index minus first plus one.
// - Norms quantised each frame: log quantiser, 40 levels, 3 dB steps.
// - Norm index is 34 minus twice log2 of the band norm.
// - Index of band 0 saturates to 0..31, other bands to 0..39.
// - Index i reconstructs to 2 to the power 17 minus i/2.
// - Lowest band index goes out as a plain 5-bit field.
// - Differential is upper band index minus lower band index.
// - Downward pass: differential below -15 copies upper index to lower.
// - Upward pass: differential above 16 forces upper to lower plus 16.
// - Adjusted differential plus 15 gives symbols 0..31.
// - All four coding modes costed; cheapest one is used.
// - Mode field 2 bits: 0 context, 1 resized, 2 normal, 3 direct.
// - Direct mode writes each symbol as a 5-bit field.
// - Context mode: first index minus offset, then previous symbol.
// - Normal mode maps symbols to fixed 3 to 7 bit codes.
// - Resized mode uses the low-rate resized code on the symbols.
// - 26 bands for wideband, 44 for fullband.
// - Harmonic layout for harmonic modes, wideband layout, else default.
`ifndef BNQ_DEFINES_SVH
`define BNQ_DEFINES_SVH
// Band counts per layout
`define BNQ_NB_WB 6'h1a
`define BNQ_NB_FB 6'h2c
`define BNQ_NB_SWB 6'h27
`define BNQ_NB_HARM 6'h1f
// Quantiser: top index (log2 zero point) and saturation limits
`define BNQ_IDX_TOP 6'h22
`define BNQ_IDX0_MAX 6'h1f
`define BNQ_IDX_MAX 6'h27
`define BNQ_HALF8 12'sh004
// Differential limits and symbol offset
`define BNQ_DIF_MIN (-7'sh0f)
`define BNQ_DIF_MAX 7'sh10
`define BNQ_SYM_OFS 7'sh0f
// Field widths
`define BNQ_FIRST_W 5'h05
`define BNQ_MODE_W 5'h02
`define BNQ_DIRECT_W 5'h05
`endif

/* File: rtl/bnq_pkg.sv */
// Types of the band norm quantiser and coder.
// Needs nothing from the constants header.
package bnq_pkg;
  // Norm coding modes as signalled in the mode field
  typedef enum logic [1:0] {
    MODE_CTX = 2'h0,
    MODE_RSZ = 2'h1,
    MODE_NRM = 2'h2,
    MODE_DIR = 2'h3
  } bnq_mode_t;
  // Band layouts
  typedef enum logic [1:0] {
    LAY_DEFAULT = 2'h0,
    LAY_WIDE = 2'h1,
    LAY_HARM = 2'h2
  } bnq_layout_t;
  // Frame sequencer states, one-hot
  typedef enum logic [8:0] {
    S_IDLE = 9'h001,
    S_ACC = 9'h002,
    S_QNT = 9'h004,
    S_DN = 9'h008,
    S_UP = 9'h010,
    S_CST = 9'h020,
    S_EMH = 9'h040,
    S_EMS = 9'h080,
    S_NRM = 9'h100
  } bnq_state_t;
endpackage : bnq_pkg

/* File: rtl/bnq_fifo.sv */
// Field FIFO between the coder and the bit serialiser.
// Single clock; DEPTH a power of two.
`timescale 1ns/1ps
module bnq_fifo #(
  parameter int WIDTH = 21,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;

  // Handshake decode
  wire do_wr = in_valid_i && in_ready_o;
  wire do_rd = out_valid_o && out_ready_i;
  assign in_ready_o = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o = mem[rd_ptr];

  // Storage
  always_ff @(posedge clock_i) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (do_wr) wr_ptr <= wr_ptr + 1'b1;
      if (do_rd) rd_ptr <= rd_ptr + 1'b1;
      count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
endmodule : bnq_fifo

/* File: rtl/bnq_coder.sv */
// Band norm quantiser and differential norm coder, top level.
// Coefficients arrive band by band with a last flag; resized and
// context code tables sit outside and answer lut_* combinationally.
`timescale 1ns/1ps
`include "bnq_defines.svh"
module bnq_coder
  import bnq_pkg::*;
#(
  parameter int COEF_W = 18,
  parameter int MAX_BANDS = 44,
  parameter int FIFO_DEPTH = 8,
  parameter logic [5:0] FIRST_CTX_OFS = 6'h00
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Frame configuration, taken at frame start
  input wire logic wideband_i,
  input wire logic fullband_i,
  input wire logic harmonic_i,
  input wire logic harmonic_vector_mode_i,
  // Coefficient stream
  input wire logic coef_valid_i,
  input wire logic signed [COEF_W-1:0] coef_i,
  input wire logic coef_band_last_i,
  output logic coef_ready_o,
  // External resized and context code tables
  output logic [4:0] lut_sym_o,
  output logic [5:0] lut_ctx_o,
  input wire logic [15:0] rsz_code_i,
  input wire logic [4:0] rsz_len_i,
  input wire logic [15:0] ctx_code_i,
  input wire logic [4:0] ctx_len_i,
  // Serial bitstream
  output logic bit_valid_o,
  output logic bit_o,
  input wire logic bit_ready_i,
  // Results for bit allocation
  output logic [1:0] band_layout_o,
  output logic [1:0] norm_mode_o,
  output logic norm_valid_o,
  output logic [5:0] norm_band_o,
  output logic [5:0] norm_idx_o,
  output logic signed [6:0] norm_half_exp_o,
  output logic frame_done_o
);
  // Log2 in eighths: msb position and three fraction bits
  function automatic logic [8:0] log8(input logic [47:0] x);
    logic [5:0] p;
    logic [47:0] n;
    p = 6'h00;
    for (int i = 0; i < 48; i++) begin
      if (x[i]) p = 6'(i);
    end
    n = x << (6'h2f - p);
    return {p, n[46:44]};
  endfunction : log8

  // Normal Huffman length and code for a symbol
  function automatic logic [20:0] nrm_code(input logic [4:0] s);
    logic [1:0] lo;
    lo = s[1:0];
    case (s[4:2])
      3'h0: nrm_code = {5'h07, 9'h0, lo, 5'h1a};
      3'h1: nrm_code = {5'h07, 9'h0, lo, 5'h1b};
      3'h2: nrm_code = {5'h06, 10'h0, lo, 4'hc};
      3'h3: nrm_code = s[1] ? {5'h03, 13'h0, 1'b1, s[0], 1'b0}
                            : {5'h04, 13'h0, s[0], 2'h2};
      3'h4: nrm_code = s[1] ? {5'h04, 12'h0, 1'b1, s[0], 2'h2}
                            : {5'h03, 13'h0, 1'b0, s[0], 1'b0};
      3'h5: nrm_code = {5'h06, 10'h0, lo, 4'he};
      3'h6: nrm_code = {5'h07, 9'h0, lo, 5'h1e};
      default: nrm_code = {5'h07, 9'h0, lo, 5'h1f};
    endcase
  endfunction : nrm_code

  bnq_state_t st, next_st;
  logic [5:0] idx [0:MAX_BANDS-1];
  logic [5:0] nb, band, b_cnt;
  logic [9:0] kpos, kstart, kend;
  logic [47:0] sumsq;
  logic ph, hdr;
  logic [9:0] cost_c, cost_r, cost_n;
  bnq_mode_t mode;
  logic [15:0] sh;
  logic [4:0] rem;

  // Coefficient accept and squared sum
  wire acc = coef_valid_i && coef_ready_o;
  wire [2*COEF_W-1:0] sq = (2*COEF_W)'(coef_i * coef_i);
  wire [47:0] next_sum = sumsq + 48'(sq);

  // Index from log2 of the mean square: 34 - log2(sum) + log2(len)
  wire [9:0] band_len = (kend - kstart) + 10'h001;
  wire signed [11:0] q8 = {3'h0, `BNQ_IDX_TOP, 3'h0}
                        + {3'h0, log8(48'(band_len))}
                        - {3'h0, log8(sumsq)};
  wire signed [8:0] q = 9'((q8 + `BNQ_HALF8) >>> 3);
  wire [5:0] q_lim = (band == 6'h00) ? `BNQ_IDX0_MAX : `BNQ_IDX_MAX;
  // Silent band has an infinite index: goes to the limit
  wire [5:0] q_sat = (sumsq == '0) ? q_lim : (q < 0) ? 6'h00 :
                     (q > $signed({3'h0, q_lim})) ? q_lim : q[5:0];

  // Differential of the pair at b_cnt and its symbol
  wire [5:0] b_up = b_cnt + 6'h01;
  wire [5:0] b_pr = (b_cnt == 6'h00) ? 6'h00 : b_cnt - 6'h01;
  wire signed [6:0] dif = $signed({1'b0, idx[b_up]})
                        - $signed({1'b0, idx[b_cnt]});
  wire signed [6:0] dif_pr = $signed({1'b0, idx[b_cnt]})
                           - $signed({1'b0, idx[b_pr]});
  wire dn_fix = dif < `BNQ_DIF_MIN;
  wire up_fix = dif > `BNQ_DIF_MAX;
  wire [4:0] cur_sym = 5'(dif + `BNQ_SYM_OFS);
  wire [5:0] cur_ctx = (b_cnt == 6'h00) ? idx[0] - FIRST_CTX_OFS
                       : {1'b0, 5'(dif_pr + `BNQ_SYM_OFS)};
  wire [20:0] nrm = nrm_code(cur_sym);
  wire last_pair = (b_cnt == nb - 6'h02);

  // Cheapest mode, lower index wins a tie
  wire [9:0] cost_d = 10'(nb - 6'h01) * 10'(`BNQ_DIRECT_W);
  wire [9:0] min_cr = (cost_r < cost_c) ? cost_r : cost_c;
  wire [9:0] min_crn = (cost_n < min_cr) ? cost_n : min_cr;
  wire [9:0] min_all = (cost_d < min_crn) ? cost_d : min_crn;
  wire [9:0] cost_of [0:3];
  assign cost_of[0] = cost_c;
  assign cost_of[1] = cost_r;
  assign cost_of[2] = cost_n;
  assign cost_of[3] = cost_d;
  wire bnq_mode_t best_mode = (min_all == cost_c) ? MODE_CTX :
                              (min_all == cost_r) ? MODE_RSZ :
                              (min_all == cost_n) ? MODE_NRM : MODE_DIR;

  // Field selection for the FIFO: {length, right-aligned code}
  wire [20:0] sym_field = (mode == MODE_CTX) ? {ctx_len_i, ctx_code_i} :
                          (mode == MODE_RSZ) ? {rsz_len_i, rsz_code_i} :
                          (mode == MODE_NRM) ? nrm :
                          {`BNQ_DIRECT_W, 11'h0, cur_sym};
  wire [20:0] hdr_field = hdr ? {`BNQ_MODE_W, 14'h0, best_mode}
                              : {`BNQ_FIRST_W, 11'h0, idx[0][4:0]};
  wire push = ((st == S_EMS) && ph) || (st == S_EMH);
  wire [20:0] push_data = (st == S_EMH) ? hdr_field : sym_field;
  wire fifo_ready, fifo_ov;
  wire [20:0] fifo_od;
  wire pushed = push && fifo_ready;

  // Band count and layout from the frame configuration
  wire harm = harmonic_i || harmonic_vector_mode_i;
  wire [5:0] cfg_nb = fullband_i ? `BNQ_NB_FB : wideband_i ? `BNQ_NB_WB :
                      harm ? `BNQ_NB_HARM : `BNQ_NB_SWB;
  wire bnq_layout_t cfg_lay = harm ? LAY_HARM :
                              wideband_i ? LAY_WIDE : LAY_DEFAULT;

  // Frame sequencer
  always_comb begin
    next_st = st;
    case (st)
      S_IDLE: if (coef_valid_i) next_st = S_ACC;
      S_ACC: if (acc && coef_band_last_i) next_st = S_QNT;
      S_QNT: next_st = (band == nb - 6'h01) ? S_DN : S_ACC;
      S_DN: if (b_cnt == 6'h00) next_st = S_UP;
      S_UP: if (last_pair) next_st = S_CST;
      S_CST: if (ph && last_pair) next_st = S_EMH;
      S_EMH: if (pushed && hdr) next_st = S_EMS;
      S_EMS: if (pushed && last_pair) next_st = S_NRM;
      S_NRM: if (b_cnt == nb - 6'h01) next_st = S_IDLE;
      default: next_st = S_IDLE;
    endcase
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) st <= S_IDLE;
    else st <= next_st;
  end

  // Accumulation, quantisation, band and configuration state
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sumsq <= '0;
      kpos <= '0;
      kstart <= '0;
      kend <= '0;
      band <= '0;
      nb <= `BNQ_NB_SWB;
      band_layout_o <= LAY_DEFAULT;
    end else begin
      if (st == S_IDLE) begin
        sumsq <= '0;
        kpos <= '0;
        kstart <= '0;
        band <= '0;
        nb <= cfg_nb;
        band_layout_o <= cfg_lay;
      end
      if (acc) begin
        sumsq <= next_sum;
        kend <= kpos;
        kpos <= kpos + 10'h001;
      end
      if (st == S_QNT) begin
        sumsq <= '0;
        kstart <= kend + 10'h001;
        band <= band + 6'h01;
      end
    end
  end

  // Index store: quantise, then the two limiting passes
  always_ff @(posedge clock_i) begin
    if (st == S_QNT) idx[band] <= q_sat;
    if (st == S_DN && dn_fix) idx[b_cnt] <= idx[b_up];
    if (st == S_UP && up_fix) idx[b_up] <= idx[b_cnt] + 6'h10;
  end

  // Pair counter, phase and header step
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      b_cnt <= '0;
      ph <= 1'b0;
      hdr <= 1'b0;
    end else begin
      case (st)
        S_QNT: b_cnt <= nb - 6'h02;
        S_DN: b_cnt <= (b_cnt == 6'h00) ? 6'h00 : b_cnt - 6'h01;
        S_UP: b_cnt <= last_pair ? 6'h00 : b_cnt + 6'h01;
        S_CST: begin
          ph <= ~ph;
          if (ph) b_cnt <= last_pair ? 6'h00 : b_cnt + 6'h01;
        end
        S_EMH: if (pushed) hdr <= ~hdr;
        S_EMS: begin
          if (!ph) ph <= 1'b1;
          else if (pushed) begin
            ph <= 1'b0;
            b_cnt <= last_pair ? 6'h00 : b_cnt + 6'h01;
          end
        end
        S_NRM: b_cnt <= (b_cnt == nb - 6'h01) ? 6'h00 : b_cnt + 6'h01;
        default: begin
          ph <= 1'b0;
          hdr <= 1'b0;
        end
      endcase
    end
  end

  // Mode costing and table query
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cost_c <= '0;
      cost_r <= '0;
      cost_n <= '0;
      mode <= MODE_CTX;
      lut_sym_o <= '0;
      lut_ctx_o <= '0;
      norm_mode_o <= '0;
    end else begin
      lut_sym_o <= cur_sym;
      lut_ctx_o <= cur_ctx;
      if (st == S_UP) begin
        cost_c <= '0;
        cost_r <= '0;
        cost_n <= '0;
      end
      if (st == S_CST && ph) begin
        cost_c <= cost_c + 10'(ctx_len_i);
        cost_r <= cost_r + 10'(rsz_len_i);
        cost_n <= cost_n + 10'(nrm[20:16]);
      end
      if (st == S_EMH && !hdr) begin
        mode <= best_mode;
        norm_mode_o <= best_mode;
      end
    end
  end

  // Reconstructed indices once the frame is coded
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      norm_valid_o <= 1'b0;
      norm_band_o <= '0;
      norm_idx_o <= '0;
      norm_half_exp_o <= '0;
      frame_done_o <= 1'b0;
      coef_ready_o <= 1'b0;
    end else begin
      coef_ready_o <= (next_st == S_ACC);
      norm_valid_o <= (st == S_NRM);
      norm_band_o <= b_cnt;
      norm_idx_o <= idx[b_cnt];
      norm_half_exp_o <= $signed({1'b0, `BNQ_IDX_TOP})
                       - $signed({1'b0, idx[b_cnt]});
      frame_done_o <= (st == S_NRM) && (b_cnt == nb - 6'h01);
    end
  end

  bnq_fifo #(.WIDTH(21), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .in_valid_i(push),
    .in_ready_o(fifo_ready),
    .in_data_i(push_data),
    .out_valid_o(fifo_ov),
    .out_ready_i(rem == 5'h00),
    .out_data_o(fifo_od)
  );

  // Serialiser: each field leaves msb first
  wire ser_go = (rem != 5'h00) && (!bit_valid_o || bit_ready_i);
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sh <= '0;
      rem <= '0;
      bit_o <= 1'b0;
      bit_valid_o <= 1'b0;
    end else begin
      if (rem == 5'h00 && fifo_ov) begin
        sh <= fifo_od[15:0];
        rem <= fifo_od[20:16];
      end else if (ser_go) begin
        rem <= rem - 5'h01;
      end
      if (ser_go) begin
        bit_o <= sh[4'(rem - 5'h01)];
        bit_valid_o <= 1'b1;
      end else if (bit_ready_i) begin
        bit_valid_o <= 1'b0;
      end
    end
  end

  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);

  chk_first_sat: assert property (st == S_QNT && band == 6'h00
    |=> idx[0] <= `BNQ_IDX0_MAX)
    else $error("band 0 index above 31");
  chk_down_fix: assert property (st == S_DN && dn_fix
    |=> idx[$past(b_cnt)] == idx[$past(b_up)])
    else $error("low index not copied from upper");
  chk_up_clamp: assert property (st == S_UP && up_fix
    |=> idx[$past(b_up)] == idx[$past(b_cnt)] + 6'h10)
    else $error("upper index not clamped to lower plus 16");
  chk_diff_range: assert property (st == S_EMS
    |-> dif >= `BNQ_DIF_MIN && dif <= `BNQ_DIF_MAX)
    else $error("differential outside -15..16");
  chk_mode_min: assert property ($rose(st == S_EMS)
    |-> cost_of[mode] == min_all)
    else $error("chosen mode not the cheapest");
  chk_first_field: assert property (st == S_EMH && !hdr && pushed
    |=> st == S_EMH && hdr)
    else $error("first index field not followed by mode field");
  chk_direct_width: assert property (st == S_EMS && pushed
    && mode == MODE_DIR |-> push_data[20:16] == 5'h05)
    else $error("direct field not 5 bits");
  chk_normal_code: assert property (st == S_EMS && mode == MODE_NRM
    && cur_sym == 5'h10 |-> push_data == {5'h03, 16'h0000})
    else $error("symbol 16 not coded 000");
  chk_recon_exp: assert property (norm_valid_o
    |-> norm_half_exp_o == 7'sh22 - $signed({1'b0, norm_idx_o}))
    else $error("reconstruction exponent wrong");
  cov_direct: cover property (st == S_EMH && hdr && best_mode == MODE_DIR);
  cov_normal: cover property (st == S_EMH && hdr && best_mode == MODE_NRM);
  cov_down_fix: cover property (st == S_DN && dn_fix);
  cov_done: cover property (frame_done_o);
endmodule : bnq_coder

/* File: bench/bnq_far_model.sv */
// Far side model: resized and context code tables, bit sink.
// Assumes the coder's table and serial bit ports, one clock.
`timescale 1ns/1ps
module bnq_far_model (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Table queries and code widths
  input wire logic [4:0] lut_sym_i,
  input wire logic [5:0] lut_ctx_i,
  input wire logic [4:0] rsz_w_i,
  input wire logic [4:0] ctx_w_i,
  output logic [15:0] rsz_code_o,
  output logic [4:0] rsz_len_o,
  output logic [15:0] ctx_code_o,
  output logic [4:0] ctx_len_o,
  // Bit sink
  input wire logic [1:0] stall_i,
  input wire logic bit_valid_i,
  input wire logic bit_i,
  output logic bit_ready_o
);
  logic [7:0] cyc;
  logic seen[$];
  // Codes carry the queried value, cut to the code width
  assign rsz_code_o = {11'h000, lut_sym_i} & 16'((17'h1 << rsz_w_i) - 17'h1);
  assign rsz_len_o = rsz_w_i;
  assign ctx_code_o = {10'h000, lut_ctx_i} & 16'((17'h1 << ctx_w_i) - 17'h1);
  assign ctx_len_o = ctx_w_i;
  // Ready always, one cycle in eight, or every other cycle
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cyc <= 8'h00;
      bit_ready_o <= 1'b0;
    end else begin
      cyc <= cyc + 8'h01;
      bit_ready_o <= (stall_i == 2'h0) || (stall_i == 2'h2 && cyc[0]) ||
        (stall_i == 2'h1 && cyc[2:0] == 3'h0);
    end
  end
  // Bits taken, in order
  always @(posedge clock_i) begin
    if (bit_valid_i === 1'b1 && bit_ready_o === 1'b1) seen.push_back(bit_i);
  end
endmodule : bnq_far_model

/* File: bench/tb_top.sv */
// Self-checking bench of the norm quantiser and coder.
// Drives coefficients band by band; far model answers tables, takes bits.
`timescale 1ns/1ps
module tb_top;
  import bnq_pkg::*;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic wideband_i = 1'b0;
  logic fullband_i = 1'b0;
  logic harmonic_i = 1'b0;
  logic harmonic_vector_mode_i = 1'b0;
  logic coef_valid_i = 1'b0;
  logic signed [17:0] coef_i = 18'sh00000;
  logic coef_band_last_i = 1'b0;
  logic [4:0] rsz_w = 5'h10;
  logic [4:0] ctx_w = 5'h10;
  logic [1:0] stall = 2'h0;
  wire logic coef_ready_o, bit_valid_o, bit_o, bit_ready_i;
  wire logic norm_valid_o, frame_done_o;
  wire logic [4:0] lut_sym_o, rsz_len_i, ctx_len_i;
  wire logic [5:0] lut_ctx_o, norm_band_o, norm_idx_o;
  wire logic [15:0] rsz_code_i, ctx_code_i;
  wire logic [1:0] band_layout_o, norm_mode_o;
  wire logic signed [6:0] norm_half_exp_o;
  int fails = 0;
  int comparisons = 0;
  int nb;
  int mode;
  int ex[44];
  int ln[44];
  int idx[44];
  int sym[44];
  logic q[$];
  logic [23:0] mon[$];
  logic [6:0] nc[32] = '{7'h1a, 7'h3a, 7'h5a, 7'h7a, 7'h1b, 7'h3b, 7'h5b,
    7'h7b, 7'h0c, 7'h1c, 7'h2c, 7'h3c, 7'h02, 7'h06, 7'h04, 7'h06, 7'h00,
    7'h02, 7'h0a, 7'h0e, 7'h0e, 7'h1e, 7'h2e, 7'h3e, 7'h1e, 7'h3e, 7'h5e,
    7'h7e, 7'h1f, 7'h3f, 7'h5f, 7'h7f};

  bnq_coder bnq_coder_inst (
    .clock_i(clock_i), .rst_i(rst_i), .wideband_i(wideband_i),
    .fullband_i(fullband_i), .harmonic_i(harmonic_i),
    .harmonic_vector_mode_i(harmonic_vector_mode_i),
    .coef_valid_i(coef_valid_i), .coef_i(coef_i),
    .coef_band_last_i(coef_band_last_i), .coef_ready_o(coef_ready_o),
    .lut_sym_o(lut_sym_o), .lut_ctx_o(lut_ctx_o), .rsz_code_i(rsz_code_i),
    .rsz_len_i(rsz_len_i), .ctx_code_i(ctx_code_i), .ctx_len_i(ctx_len_i),
    .bit_valid_o(bit_valid_o), .bit_o(bit_o), .bit_ready_i(bit_ready_i),
    .band_layout_o(band_layout_o), .norm_mode_o(norm_mode_o),
    .norm_valid_o(norm_valid_o), .norm_band_o(norm_band_o),
    .norm_idx_o(norm_idx_o), .norm_half_exp_o(norm_half_exp_o),
    .frame_done_o(frame_done_o));

  bnq_far_model bnq_far_model_inst (
    .clock_i(clock_i), .rst_i(rst_i), .lut_sym_i(lut_sym_o),
    .lut_ctx_i(lut_ctx_o), .rsz_w_i(rsz_w), .ctx_w_i(ctx_w),
    .rsz_code_o(rsz_code_i), .rsz_len_o(rsz_len_i), .ctx_code_o(ctx_code_i),
    .ctx_len_o(ctx_len_i), .stall_i(stall), .bit_valid_i(bit_valid_o),
    .bit_i(bit_o), .bit_ready_o(bit_ready_i));

  // Clock, 25 ns period
  always #12.5 clock_i = ~clock_i;
  // Norm results with mode, layout and end marker
  always @(posedge clock_i) begin
    if (norm_valid_o === 1'b1) mon.push_back({band_layout_o, norm_mode_o,
      frame_done_o, norm_band_o, norm_idx_o, norm_half_exp_o});
  end

  task automatic check(input string what, input logic [31:0] got,
                       input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic report_and_stop();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  // Normal code length per symbol
  function automatic int nlen(input int s);
    if (s < 8 || s > 23) return 7;
    if (s < 12 || s > 19) return 6;
    return (s > 13 && s < 18) ? 3 : 4;
  endfunction : nlen

  // Field into the expected bit queue, msb first
  task automatic put(input int v, input int w);
    for (int i = w - 1; i >= 0; i--) q.push_back(v[i]);
  endtask : put

  // Expected indices, symbols, mode and bitstream
  task automatic predict();
    int c[4];
    for (int b = 0; b < nb; b++) begin
      idx[b] = ex[b] < 0 ? 99 : 34 - 2 * ex[b];
      if (idx[b] > (b ? 39 : 31)) idx[b] = b ? 39 : 31;
    end
    for (int b = nb - 2; b >= 0; b--) begin
      if (idx[b+1] - idx[b] < -15) idx[b] = idx[b+1];
    end
    c = '{0, 0, 0, 0};
    for (int b = 0; b < nb - 1; b++) begin
      if (idx[b+1] - idx[b] > 16) idx[b+1] = idx[b] + 16;
      sym[b] = idx[b+1] - idx[b] + 15;
      c[0] += ctx_w;
      c[1] += rsz_w;
      c[2] += nlen(sym[b]);
      c[3] += 5;
    end
    mode = 0;
    for (int m = 1; m < 4; m++) if (c[m] < c[mode]) mode = m;
    q.delete();
    put(idx[0], 5);
    put(mode, 2);
    for (int b = 0; b < nb - 1; b++) begin
      case (mode)
        0: put(b ? sym[b-1] : idx[0], ctx_w);
        1: put(sym[b], rsz_w);
        2: put(nc[sym[b]], nlen(sym[b]));
        default: put(sym[b], 5);
      endcase
    end
  endtask : predict

  // One coefficient, held until taken
  task automatic send(input logic signed [17:0] c, input logic last);
    int n;
    n = 0;
    coef_valid_i <= 1'b1;
    coef_i <= c;
    coef_band_last_i <= last;
    do begin
      @(posedge clock_i);
      n++;
    end while (coef_ready_o !== 1'b1 && n < 50);
    check("coef taken", coef_ready_o, 1'b1);
  endtask : send

  // Full frame: drive bands, wait for norms and bits, compare
  task automatic run(input int n_b, input logic [3:0] cfg,
                     input logic [1:0] lay);
    int k;
    logic signed [17:0] a;
    nb = n_b;
    mon.delete();
    bnq_far_model_inst.seen.delete();
    @(posedge clock_i);
    predict();
    {wideband_i, fullband_i, harmonic_i, harmonic_vector_mode_i} <= cfg;
    @(posedge clock_i);
    for (int b = 0; b < nb; b++) begin
      // Spike of twice the level over four gives the same rms
      a = ex[b] < 0 ? 18'sh00000 : 18'sh00001 <<< (ex[b] + (ln[b] > 1));
      for (int j = 0; j < ln[b]; j++) begin
        send(j ? 18'sh00000 : (b % 2 ? -a : a), j == ln[b] - 1);
      end
    end
    coef_valid_i <= 1'b0;
    k = 0;
    while ((mon.size() < nb || bnq_far_model_inst.seen.size() < q.size())
           && k < 9000) begin
      @(posedge clock_i);
      k++;
    end
    repeat (20) @(posedge clock_i);
    check("band count", mon.size(), nb);
    for (int b = 0; b < nb; b++) begin
      check("norm", mon[b], {lay, 2'(mode), 1'(b == nb - 1), 6'(b),
        6'(idx[b]), 7'(34 - idx[b])});
    end
    check("bit count", bnq_far_model_inst.seen.size(), q.size());
    for (int i = 0; i < q.size(); i++) begin
      check("bit", bnq_far_model_inst.seen[i], q[i]);
    end
  endtask : run

  // Zero band, both clamps, normal codes incl. symbol 16, slow sink
  task automatic t_default_mixed();
    int e[9] = '{-1, 1, 5, 12, 0, 16, 0, 0, -1};
    for (int b = 0; b < 39; b++) begin
      ex[b] = b < 9 ? e[b] : 0;
      ln[b] = b % 3 ? 1 : 4;
    end
    rsz_w <= 5'h10;
    ctx_w <= 5'h10;
    stall <= 2'h1;
    run(39, 4'h0, 2'h0);
  endtask : t_default_mixed

  // Wideband, six-bit normal codes lose to direct packing
  task automatic t_wide_direct();
    for (int b = 0; b < 26; b++) begin
      ex[b] = b % 2 ? 9 : 12;
      ln[b] = 4;
    end
    stall <= 2'h0;
    run(26, 4'h8, 2'h1);
  endtask : t_wide_direct

  // Fullband, cheap resized table wins
  task automatic t_full_resized();
    for (int b = 0; b < 44; b++) begin
      ex[b] = 8 + b % 3;
      ln[b] = 1;
    end
    rsz_w <= 5'h02;
    stall <= 2'h2;
    run(44, 4'h4, 2'h0);
  endtask : t_full_resized

  // Harmonic layouts, cheap context table wins
  task automatic t_harm_context(input logic [3:0] cfg);
    for (int b = 0; b < 31; b++) begin
      ex[b] = 8 + b % 2;
      ln[b] = b % 2 ? 4 : 1;
    end
    ctx_w <= 5'h01;
    rsz_w <= 5'h02;
    run(31, cfg, 2'h2);
  endtask : t_harm_context

  // Main sequence
  initial begin
    repeat (8) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    check("idle outputs", {coef_ready_o, bit_valid_o, norm_valid_o,
      frame_done_o}, 4'h0);
    t_default_mixed();
    t_wide_direct();
    t_full_resized();
    t_harm_context(4'h2);
    t_harm_context(4'h1);
    report_and_stop();
  end

  // Watchdog
  initial begin
    repeat (60000) @(posedge clock_i);
    fails++;
    report_and_stop();
  end
endmodule : tb_top
